/* File: dv/smp_requester.sv */
// Requester model for the memory port of the protected block.
// Assumes the read answer arrives one cycle after the taking edge.
`timescale 1ns/1ps
module smp_requester
  import smp_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Request side.
  output logic memReq,
  output logic memWe,
  output logic [ADDR_W-1:0] memAddr,
  output logic [DATA_W-1:0] memWdata,
  // Answer side.
  input wire logic memRvalid,
  input wire logic [DATA_W-1:0] memRdata,
  input wire logic memSecErr,
  input wire logic memDedErr,
  input wire logic memAbort,
  input wire logic monSingleErr
);
  initial
  begin
    memReq = 1'b0;
    memWe = 1'b0;
    memAddr = 4'h0;
    memWdata = 64'h0;
  end

  // Released address and data lines show the inverse, so a stale value is never trusted.
  task automatic put(input logic we, input logic [3:0] a,
                     input logic [63:0] d);
    @(posedge core_clk);
    memReq <= 1'b1;
    memWe <= we;
    memAddr <= a;
    memWdata <= d;
    @(posedge core_clk);
    memReq <= 1'b0;
    memAddr <= ~a;
    memWdata <= ~d;
  endtask

  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    put(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, output logic [63:0] d,
                    output logic [4:0] fl);
    put(1'b0, a, 64'h0);
    @(posedge core_clk);
    d = memRdata;
    fl = {memRvalid, memSecErr, memDedErr, memAbort, monSingleErr};
  endtask
endmodule

/* File: dv/smp_secded_protect_bench.sv */
// Self-checking bench of the protected memory block.
// Assumes an APB slave that answers through pready and the requester
// model beside it.
`timescale 1ns/1ps
module smp_secded_protect_bench
  import smp_pkg::*;
;
  localparam logic [63:0] D = 64'h0123_4567_89AB_CDEF;
  logic core_clk, resetn, psel, penable, pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, memReq, memWe, memRvalid;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] memWdata, memRdata;
  logic memSecErr, memDedErr, memAbort, monSingleErr, irqHigh, irqLow;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  smp_secded_protect dut_u (.core_clk, .resetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .memReq,
    .memWe, .memAddr, .memWdata, .memRvalid, .memRdata, .memSecErr,
    .memDedErr, .memAbort, .monSingleErr, .irqHigh, .irqLow);
  smp_requester req_u (.core_clk, .memReq, .memWe, .memAddr,
    .memWdata, .memRvalid, .memRdata, .memSecErr, .memDedErr,
    .memAbort, .monSingleErr);

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // The wait ends when pready is 1; if pready never rises, only the bench timeout ends it.
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // The expected value carries the slave error bit on top.
  task automatic rreg(input logic [7:0] a, input logic [32:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk({31'h0, e, r}, {31'h0, exp});
  endtask

  task automatic mrd(input logic [3:0] a, input logic [63:0] d,
                     input logic [4:0] fl);
    logic [63:0] g;
    logic [4:0] f;
    req_u.rd(a, g, f);
    chk(g, d);
    chk({59'h0, f}, {59'h0, fl});
  endtask

  // Flags are valid, single, double, abort and monitor single.
  task automatic mflag(input logic [3:0] a, input logic [4:0] fl);
    logic [63:0] g;
    logic [4:0] f;
    req_u.rd(a, g, f);
    chk({59'h0, f}, {59'h0, fl});
  endtask

  // Injection stays armed after the write, so the read can follow at once;
  // every later write goes through this task and sets its own mask.
  task automatic winj(input logic [3:0] a, input logic [15:0] inj);
    wreg(OFS_INJECT, {16'h0000, inj});
    req_u.wr(a, D);
  endtask

  task automatic t_reset();
    rreg(OFS_CTRL, {25'h000_0000, CTRL_RST});
    rreg(OFS_AGG_CFG, 33'h0_0000_0000);
    rreg(OFS_SEC_COUNT, 33'h0_0000_0000);
    rreg(8'h18, 33'h1_0000_0000);
    chk({62'h0, irqHigh, irqLow}, 64'h0);
  endtask

  task automatic t_clean();
    req_u.wr(4'h3, D);
    req_u.wr(4'h4, ~D);
    mrd(4'h3, D, 5'h10);
    mrd(4'h4, ~D, 5'h10);
  endtask

  task automatic t_single();
    logic [6:0] idx [4] = '{7'h00, 7'h3F, 7'h40, 7'h47};
    wreg(OFS_CTRL, 32'h0000_0001);
    foreach (idx[i])
    begin
      winj(4'h5, {8'h00, 1'b1, idx[i]});
      mrd(4'h5, D, 5'h1A);
    end
    rreg(OFS_SEC_COUNT, 33'h0_0000_0004);
    rreg(OFS_ERR_ADDR, 33'h0_0000_0005);
  endtask

  task automatic t_double();
    wreg(OFS_CTRL, 32'h0000_0002);
    winj(4'h6, 16'h008A);
    mrd(4'h6, D, 5'h18);
    winj(4'h6, 16'h8180);
    mflag(4'h6, 5'h16);
    rreg(OFS_ERR_ADDR, 33'h0_0001_0006);
    // Role code 3 checks, corrects and flags memSecErr but never aborts or sets an aggregator flag.
    wreg(OFS_CTRL, 32'h0000_0033);
    winj(4'h6, 16'h0085);
    mrd(4'h6, D, 5'h18);
  endtask

  task automatic t_mon();
    wreg(OFS_CTRL, 32'h0000_0010);
    wreg(OFS_AGG_CFG, 32'h0000_0044);
    winj(4'h7, 16'h0087);
    mrd(4'h7, D, 5'h19);
    chk({62'h0, irqHigh, irqLow}, 64'h0);
    winj(4'h7, 16'h8382);
    mflag(4'h7, 5'h14);
    chk({62'h0, irqHigh, irqLow}, 64'h2);
    rreg(OFS_AGG_STAT, 33'h0_0000_0004);
    wreg(OFS_AGG_STAT, 32'h0000_0004);
    rreg(OFS_AGG_STAT, 33'h0_0000_0000);
    chk({62'h0, irqHigh, irqLow}, 64'h0);
  endtask

  task automatic t_periph();
    wreg(OFS_CTRL, 32'h0000_0020);
    wreg(OFS_AGG_CFG, 32'h0000_0003);
    winj(4'h8, 16'h0080);
    mrd(4'h8, D ^ 64'h1, 5'h10);
    wreg(OFS_CTRL, 32'h0000_0024);
    winj(4'h8, 16'h0080);
    mrd(4'h8, D, 5'h18);
    rreg(OFS_AGG_STAT, 33'h0_0000_0001);
    chk({62'h0, irqHigh, irqLow}, 64'h1);
    winj(4'h9, 16'h8180);
    mflag(4'h9, 5'h14);
    rreg(OFS_AGG_STAT, 33'h0_0000_0003);
    wreg(OFS_AGG_STAT, 32'h0000_0003);
    wreg(OFS_AGG_CFG, 32'h0000_0002);
    winj(4'h8, 16'h0080);
    mrd(4'h8, D, 5'h18);
    rreg(OFS_AGG_STAT, 33'h0_0000_0000);
    chk({62'h0, irqHigh, irqLow}, 64'h0);
  endtask

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_clean();
    t_single();
    t_double();
    t_mon();
    t_periph();
    end_of_test();
  end
endmodule

/* File: hdl/smp_pkg.sv */
// Constants, types and check-code functions of the SECDED memory protection.
// Assumes one clock domain and an APB master with 32-bit data.
package smp_pkg;
  localparam int DATA_W = 64;
  localparam int CODE_W = 8;
  localparam int WORD_W = 72;
  localparam int HALF_W = 36;
  localparam int ADDR_W = 4;
  localparam int DEPTH = 16;
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AGG_CFG = 8'h04;
  localparam logic [7:0] OFS_AGG_STAT = 8'h08;
  localparam logic [7:0] OFS_INJECT = 8'h0C;
  localparam logic [7:0] OFS_ERR_ADDR = 8'h10;
  localparam logic [7:0] OFS_SEC_COUNT = 8'h14;
  localparam int CTRL_SEC_ABORT = 0;
  localparam int CTRL_DED_ABORT = 1;
  localparam int CTRL_PERIPH_EN = 2;
  localparam int CTRL_ROLE = 4;
  localparam int CH_SEC = 0;
  localparam int CH_DED = 1;
  localparam int CH_MON = 2;
  localparam int CH_N = 3;
  localparam int AGG_PRIO = 4;
  localparam int INJ_A = 0;
  localparam int INJ_A_EN = 7;
  localparam int INJ_B = 8;
  localparam int INJ_B_EN = 15;
  localparam int ERR_DED_BIT = 16;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AGG_CFG_RST = 8'h00;
  localparam logic [15:0] INJECT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  typedef enum logic [1:0] {ROLE_MAIN_TCM, ROLE_MON_TCM, ROLE_PERIPH} smp_role_t;

  // Syndrome column of data bit idx: the idx-th non power of two from 3 on.
  function automatic logic [6:0] smp_dpos(input int idx);
    int pos;
    pos = 2;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (i <= idx)
      begin
        pos = pos + 1;
        if ((pos & (pos - 1)) == 0)
          pos = pos + 1;
      end
    end
    return pos[6:0];
  endfunction

  // The word address is folded into the code, so a wrong row gives a
  // nonzero syndrome with even parity, which decodes as uncorrectable.
  function automatic logic [7:0] smp_code(input logic [63:0] d,
                                          input logic [3:0] a);
    logic [6:0] c;
    c = {3'h0, a};
    for (int i = 0; i < DATA_W; i++)
      if (d[i])
        c = c ^ smp_dpos(i);
    return {^{d, c}, c};
  endfunction

  // Even bits go to bank A, odd bits to bank B.
  function automatic logic [71:0] smp_split(input logic [71:0] w);
    logic [71:0] s;
    for (int j = 0; j < HALF_W; j++)
    begin
      s[j] = w[2 * j];
      s[HALF_W + j] = w[2 * j + 1];
    end
    return s;
  endfunction

  function automatic logic [71:0] smp_merge(input logic [71:0] s);
    logic [71:0] w;
    for (int j = 0; j < HALF_W; j++)
    begin
      w[2 * j] = s[j];
      w[2 * j + 1] = s[HALF_W + j];
    end
    return w;
  endfunction
endpackage

/* File: hdl/smp_secded_protect.sv */
// SECDED protected two-bank memory with error routing and an APB slave.
// Assumes requests synchronous to core_clk and one request per cycle.
`timescale 1ns/1ps
module smp_secded_protect
  import smp_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // APB slave.
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Memory requester port.
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [ADDR_W-1:0] memAddr,
  input wire logic [DATA_W-1:0] memWdata,
  output logic memRvalid,
  output logic [DATA_W-1:0] memRdata,
  output logic memSecErr,
  output logic memDedErr,
  output logic memAbort,
  // Error signalling.
  output logic monSingleErr,
  output logic irqHigh,
  output logic irqLow
);
  logic [1:0] rstPipe;
  logic rstN;
  logic [HALF_W-1:0] bankA [DEPTH];
  logic [HALF_W-1:0] bankB [DEPTH];
  logic [HALF_W-1:0] next_bankA [DEPTH];
  logic [HALF_W-1:0] next_bankB [DEPTH];
  logic [7:0] ctrl, next_ctrl;
  logic [7:0] aggCfg, next_aggCfg;
  logic [CH_N-1:0] aggStat, next_aggStat;
  logic [15:0] inject, next_inject;
  logic [ADDR_W-1:0] errAddr, next_errAddr;
  logic lastDed, next_lastDed;
  logic [15:0] secCount, next_secCount;
  logic [31:0] next_prdata;
  logic next_rvalid, next_sec, next_ded, next_abort, next_monSingle;
  logic [DATA_W-1:0] next_rdata;
  logic [WORD_W-1:0] injMask, wordIn, wordSplit, rawWord;
  logic [CODE_W-1:0] calcCode;
  logic [6:0] synd;
  logic [DATA_W-1:0] fixed;
  logic par, checkOn, sgl, dbl, rdFire, wrFire, apbWr;
  logic [CH_N-1:0] evt, clr;
  smp_role_t role;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstN = rstPipe[1];

  assign role = smp_role_t'(ctrl[CTRL_ROLE +: 2]);
  assign rdFire = memReq && !memWe;
  assign wrFire = memReq && memWe;
  assign apbWr = psel && penable && pwrite;
  assign pready = psel && penable;
  assign pslverr = pready && !(paddr == OFS_CTRL || paddr == OFS_AGG_CFG ||
    paddr == OFS_AGG_STAT || paddr == OFS_INJECT ||
    paddr == OFS_ERR_ADDR || paddr == OFS_SEC_COUNT);

  // Fault injection flips up to two stored bits; it never bypasses the code.
  always_comb
  begin
    injMask = '0;
    if (inject[INJ_A_EN] && inject[INJ_A +: 7] < 7'd72)
      injMask[inject[INJ_A +: 7]] = 1'b1;
    if (inject[INJ_B_EN] && inject[INJ_B +: 7] < 7'd72)
      injMask[inject[INJ_B +: 7]] = 1'b1;
  end

  // Storage: the split has no enable and no register behind it, and
  // adjacent logical bits always land in different banks.
  always_comb
  begin
    wordIn = {smp_code(memWdata, memAddr), memWdata} ^ injMask;
    wordSplit = smp_split(wordIn);
    next_bankA = bankA;
    next_bankB = bankB;
    if (wrFire)
    begin
      next_bankA[memAddr] = wordSplit[HALF_W-1:0];
      next_bankB[memAddr] = wordSplit[WORD_W-1:HALF_W];
    end
  end

  always_ff @(posedge core_clk)
  begin
    bankA <= next_bankA;
    bankB <= next_bankB;
  end

  // Decode sits on the requester's side of the banks, so any fault along
  // the storage path or in a bank's row decode is seen here.
  always_comb
  begin
    rawWord = smp_merge({bankB[memAddr], bankA[memAddr]});
    calcCode = smp_code(rawWord[DATA_W-1:0], memAddr);
    synd = calcCode[6:0] ^ rawWord[DATA_W +: 7];
    par = ^rawWord;
    checkOn = (role != ROLE_PERIPH) || ctrl[CTRL_PERIPH_EN];
    sgl = checkOn && par;
    dbl = checkOn && !par && (synd != 7'h00);
    fixed = rawWord[DATA_W-1:0];
    for (int i = 0; i < DATA_W; i++)
      if (sgl && synd == smp_dpos(i))
        fixed[i] = ~fixed[i];
  end

  always_comb
  begin
    next_rvalid = rdFire;
    next_rdata = rdFire ? fixed : memRdata;
    next_sec = rdFire && sgl;
    next_ded = rdFire && dbl;
    next_abort = rdFire && role == ROLE_MAIN_TCM &&
      ((sgl && ctrl[CTRL_SEC_ABORT]) || (dbl && ctrl[CTRL_DED_ABORT]));
    next_monSingle = rdFire && role == ROLE_MON_TCM && sgl;
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      memRvalid <= 1'b0;
      memRdata <= '0;
      memSecErr <= 1'b0;
      memDedErr <= 1'b0;
      memAbort <= 1'b0;
      monSingleErr <= 1'b0;
    end
    else
    begin
      memRvalid <= next_rvalid;
      memRdata <= next_rdata;
      memSecErr <= next_sec;
      memDedErr <= next_ded;
      memAbort <= next_abort;
      monSingleErr <= next_monSingle;
    end
  end

  // Aggregator: a new event in the clearing cycle keeps its flag set.
  always_comb
  begin
    evt[CH_SEC] = rdFire && role == ROLE_PERIPH && sgl;
    evt[CH_DED] = rdFire && role == ROLE_PERIPH && dbl;
    evt[CH_MON] = rdFire && role == ROLE_MON_TCM && dbl;
    clr = (apbWr && paddr == OFS_AGG_STAT) ? pwdata[CH_N-1:0] : '0;
    next_aggStat = (aggStat & ~clr) | (evt & aggCfg[CH_N-1:0]);
  end
  assign irqHigh = |(aggStat & aggCfg[CH_N-1:0] &
    aggCfg[AGG_PRIO +: CH_N]);
  assign irqLow = |(aggStat & aggCfg[CH_N-1:0] &
    ~aggCfg[AGG_PRIO +: CH_N]);

  always_comb
  begin
    next_ctrl = ctrl;
    next_aggCfg = aggCfg;
    next_inject = inject;
    next_errAddr = errAddr;
    next_lastDed = lastDed;
    next_secCount = secCount;
    next_prdata = prdata;
    if (apbWr && paddr == OFS_CTRL)
      next_ctrl = pwdata[7:0];
    if (apbWr && paddr == OFS_AGG_CFG)
      next_aggCfg = pwdata[7:0];
    if (apbWr && paddr == OFS_INJECT)
      next_inject = pwdata[15:0];
    if (rdFire && (sgl || dbl))
    begin
      next_errAddr = memAddr;
      next_lastDed = dbl;
    end
    if (rdFire && sgl && secCount != COUNT_MAX)
      next_secCount = secCount + 16'h0001;
    // Read data is caught in the setup cycle so it leaves a flip-flop.
    if (psel && !penable)
    begin
      next_prdata = '0;
      case (paddr)
        OFS_CTRL: next_prdata[7:0] = ctrl;
        OFS_AGG_CFG: next_prdata[7:0] = aggCfg;
        OFS_AGG_STAT: next_prdata[CH_N-1:0] = aggStat;
        OFS_INJECT: next_prdata[15:0] = inject;
        OFS_ERR_ADDR:
        begin
          next_prdata[ADDR_W-1:0] = errAddr;
          next_prdata[ERR_DED_BIT] = lastDed;
        end
        OFS_SEC_COUNT: next_prdata[15:0] = secCount;
        default: next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl <= CTRL_RST;
      aggCfg <= AGG_CFG_RST;
      aggStat <= '0;
      inject <= INJECT_RST;
      errAddr <= '0;
      lastDed <= 1'b0;
      secCount <= '0;
      prdata <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
      aggCfg <= next_aggCfg;
      aggStat <= next_aggStat;
      inject <= next_inject;
      errAddr <= next_errAddr;
      lastDed <= next_lastDed;
      secCount <= next_secCount;
      prdata <= next_prdata;
    end
  end

  sequence s_one_flip_write;
    wrFire && inject[INJ_A_EN] && !inject[INJ_B_EN] &&
      inject[INJ_A +: 7] < 7'd72;
  endsequence
  // The read is taken two edges after the write, with one idle cycle
  // between them, so that nothing can have overwritten the row.
  sequence s_same_read;
    rdFire && checkOn && memAddr == $past(memAddr, 2);
  endsequence

  property p_code_stored;
    @(posedge core_clk) disable iff (!rstN)
    wrFire && injMask == '0 |=> smp_merge({bankB[$past(memAddr)],
      bankA[$past(memAddr)]}) == {smp_code($past(memWdata), $past(memAddr)),
      $past(memWdata)};
  endproperty
  a_code_stored: assert property (p_code_stored)
    else $error("stored word does not match its check code");

  property p_read_latency;
    @(posedge core_clk) disable iff (!rstN)
    rdFire |=> memRvalid ##1 (!memRvalid || $past(rdFire));
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not one cycle after request");

  property p_single_corrected;
    @(posedge core_clk) disable iff (!rstN)
    s_one_flip_write ##1 !memReq ##1 s_same_read |=>
      memSecErr && !memDedErr && memRdata == $past(memWdata, 3);
  endproperty
  a_single_corrected: assert property (p_single_corrected)
    else $error("single flipped bit not corrected");

  property p_abort_cfg;
    @(posedge core_clk) disable iff (!rstN)
    memRvalid && $past(role) == ROLE_MAIN_TCM |->
      memAbort == ((memSecErr && $past(ctrl[CTRL_SEC_ABORT])) ||
      (memDedErr && $past(ctrl[CTRL_DED_ABORT])));
  endproperty
  a_abort_cfg: assert property (p_abort_cfg)
    else $error("abort does not follow its enable");

  property p_mon_single;
    @(posedge core_clk) disable iff (!rstN)
    memRvalid && memSecErr && $past(role) == ROLE_MON_TCM |-> monSingleErr;
  endproperty
  a_mon_single: assert property (p_mon_single)
    else $error("monitoring core single error not signalled");

  property p_periph_off;
    @(posedge core_clk) disable iff (!rstN)
    memRvalid && $past(role) == ROLE_PERIPH &&
      !$past(ctrl[CTRL_PERIPH_EN]) |-> !memSecErr && !memDedErr;
  endproperty
  a_periph_off: assert property (p_periph_off)
    else $error("peripheral check active while disabled");

  property p_periph_report;
    @(posedge core_clk) disable iff (!rstN)
    memRvalid && memDedErr && $past(role) == ROLE_PERIPH &&
      $past(aggCfg[CH_DED]) |-> aggStat[CH_DED] && (irqHigh || irqLow);
  endproperty
  a_periph_report: assert property (p_periph_report)
    else $error("peripheral double error not reported");

  property p_mask;
    @(posedge core_clk) disable iff (!rstN)
    aggCfg[CH_N-1:0] == '0 |-> !irqHigh && !irqLow;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked error reached an interrupt");
endmodule
